//--- common/scm_map.vh
// Register map, field positions, reset values and timing counts of the clock selector
`ifndef SCM_MAP_VH
`define SCM_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCM_OFS_CTRL        8'h00
`define SCM_OFS_STAT        8'h04
`define SCM_OFS_IRQ_STAT    8'h08
`define SCM_OFS_IRQ_CLR     8'h0C
`define SCM_OFS_IRQ_EN      8'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCM_CTL_SEL_LO      0
`define SCM_CTL_SEL_HI      1
`define SCM_CTL_FACTOR      2
`define SCM_CTL_MULT_EN     3
`define SCM_CTL_AUTO_RET    4

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SCM_STA_LOCK        0
`define SCM_STA_RING        1
`define SCM_STA_SER_ACT     2
`define SCM_STA_ACT_LO      3
`define SCM_STA_ACT_HI      4
`define SCM_STA_PEND        5
`define SCM_STA_SEQ_LO      6
`define SCM_STA_SEQ_HI      9

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define SCM_IRQ_LOCK        0
`define SCM_IRQ_REJECT      1
`define SCM_IRQ_SWBACK      2
`define SCM_IRQ_W           3

// ----------------------------------------------------------------
// Selector codes and reset values
// ----------------------------------------------------------------
`define SCM_SEL_MULT        2'b00
`define SCM_SEL_RSVD        2'b01
`define SCM_SEL_DIV4        2'b10
`define SCM_SEL_PMM         2'b11
`define SCM_SEL_RST         2'b10
`define SCM_IRQ_EN_RST      3'h0

// ----------------------------------------------------------------
// Timing: sys_clk cycles per system tick and divider ratios
// ----------------------------------------------------------------
`define SCM_OSC_DIV         2'h3
`define SCM_PER_X4          10'h001
`define SCM_PER_X2          10'h002
`define SCM_PER_DIV4        10'h004
`define SCM_PER_PMM         10'h400
`define SCM_MC_DIV          2'h3
`define SCM_LOCK_OSC        65536

`endif

//--- src/scm_tick_gen.v
// Oscillator, system clock and machine-cycle tick generator
`timescale 1ns/1ns
`include "scm_map.vh"

module scm_tick_gen
(
  input  wire       sys_clk,   // Fast reference clock
  input  wire       sys_rst,   // Synchronous reset, high
  input  wire [1:0] sel,       // Active selector
  input  wire       factor,    // 0 doubles, 1 quadruples
  output reg        osc_tick,  // One pulse per oscillator period
  output reg        sys_tick,  // One pulse per system clock
  output reg        mc_tick    // One pulse per machine cycle
);

  reg  [1:0] osc_cnt_ff;
  reg  [9:0] sys_cnt_ff;
  reg  [1:0] mc_cnt_ff;
  reg  [9:0] period;
  wire       sys_hit;

  // ----------------------------------------------------------------
  // Period select: sys_clk is four oscillator clocks fast
  // ----------------------------------------------------------------
  always @*
  begin
    case (sel)
      `SCM_SEL_MULT: period = factor ? `SCM_PER_X4 : `SCM_PER_X2;  // see RQ3
      `SCM_SEL_PMM:  period = `SCM_PER_PMM;                        // see RQ1
      default:       period = `SCM_PER_DIV4;
    endcase
  end

  assign sys_hit = (sys_cnt_ff >= period - 10'h001);

  // Counters; machine cycle is four system ticks
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      osc_cnt_ff <= 2'h0;
      sys_cnt_ff <= 10'h000;
      mc_cnt_ff  <= 2'h0;
      osc_tick   <= 1'b0;
      sys_tick   <= 1'b0;
      mc_tick    <= 1'b0;
    end
    else
    begin
      osc_cnt_ff <= osc_cnt_ff + 2'h1;
      osc_tick   <= (osc_cnt_ff == `SCM_OSC_DIV);
      sys_cnt_ff <= sys_hit ? 10'h000 : sys_cnt_ff + 10'h001;
      sys_tick   <= sys_hit;
      if (sys_hit)
        mc_cnt_ff <= mc_cnt_ff + 2'h1;
      mc_tick    <= sys_hit && (mc_cnt_ff == `SCM_MC_DIV);  // see RQ2
    end
  end

endmodule

//--- src/scm_ahb_slave.v
// AHB-Lite slave front end for the clock selector registers
`timescale 1ns/1ns
`include "scm_map.vh"

module scm_ahb_slave
(
  input  wire        sys_clk,    // Clock
  input  wire        sys_rst,    // Synchronous reset, high
  input  wire        hsel,       // Slave select
  input  wire [7:0]  haddr,      // Byte address
  input  wire [1:0]  htrans,     // Transfer type
  input  wire        hwrite,     // Write when high
  input  wire [2:0]  hsize,      // Transfer size
  input  wire [31:0] hwdata,     // Write data
  input  wire        hready,     // Bus ready
  output wire        hreadyout,  // Slave ready
  output wire        hresp,      // Always OKAY
  output reg  [31:0] hrdata,     // Read data
  output wire        wr_en,      // Register write pulse
  output wire [7:0]  wr_addr,    // Register write address
  output wire [31:0] wr_data,    // Register write data
  output wire [7:0]  rd_addr,    // Register read address
  input  wire [31:0] rd_data     // Register read data
);

  reg        wr_ph_ff;
  reg        rd_ph_ff;
  reg        rd_done_ff;
  reg  [7:0] addr_ff;
  wire       start;

  assign start     = hsel && hready && htrans[1];
  assign hreadyout = ~rd_ph_ff | rd_done_ff;
  assign hresp     = 1'b0;
  assign wr_en     = wr_ph_ff;
  assign wr_addr   = addr_ff;
  assign wr_data   = hwdata;
  assign rd_addr   = addr_ff;

  // ----------------------------------------------------------------
  // Phase tracking; reads take one wait state, writes none
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ph_ff   <= 1'b0;
      rd_ph_ff   <= 1'b0;
      rd_done_ff <= 1'b0;
      addr_ff    <= 8'h00;
      hrdata     <= 32'h0000_0000;
    end
    else
    begin
      if (rd_ph_ff && !rd_done_ff)
      begin
        hrdata     <= rd_data;
        rd_done_ff <= 1'b1;
      end
      else if (hreadyout)
      begin
        wr_ph_ff   <= start && hwrite;
        rd_ph_ff   <= start && !hwrite;
        rd_done_ff <= 1'b0;
        if (start)
          addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

endmodule

//--- src/scm_top.v
// Clock source selector with multiplier engage sequence and switchback
//
// What this block does
// RQ1: Selector picks oscillator, divided by 256, or multiplied.
// RQ2: Machine cycle is system clock divided by four.
// RQ3: Selector 00 uses multiplier; factor picks x2/x4.
// RQ4: Encoding 00 multiplier/01 reserved/10 default/11 low power.
// RQ5: New rate applies one machine cycle later.
// RQ6: Selector changes only to or from 10.
// RQ7: Engage only from 10 with ring flag clear.
// RQ8: Ordered enable sequence, else selector unchanged.
// RQ9: Lock ready sets after stabilisation wait.
// RQ10: Multiplier engaged machine cycle after 00 write.
// RQ11: Leaving multiplier needs only a selector write.
// RQ12: Clearing enable, ignored while 00 is the target, stops multiplier, clears lock ready.
// RQ13: Auto return from low power on events.
// RQ14: Selector writes ignored while serial ports active.
`timescale 1ns/1ns
`include "scm_map.vh"

module scm_top
#(
  parameter LOCK_OSC_CYCLES = `SCM_LOCK_OSC  // Oscillator cycles to multiplier lock
)
(
  input  wire        sys_clk,           // Clock, 100 MHz
  input  wire        sys_rst,           // Synchronous reset, high
  input  wire        hsel,              // AHB slave select
  input  wire [7:0]  haddr,             // AHB byte address
  input  wire [1:0]  htrans,            // AHB transfer type
  input  wire        hwrite,            // AHB write
  input  wire [2:0]  hsize,             // AHB size
  input  wire [31:0] hwdata,            // AHB write data
  input  wire        hready,            // AHB ready in
  output wire        hreadyout,         // AHB ready out
  output wire        hresp,             // AHB response
  output wire [31:0] hrdata,            // AHB read data
  input  wire        ring_clock_active_flag, // Ring clock is running
  input  wire        serial_active,     // Either serial port busy
  input  wire        irq_ack,           // Interrupt acknowledged pulse
  input  wire        ser_start_bit,     // Serial start bit seen pulse
  input  wire        ser_tx_load,       // Serial transmit load pulse
  output wire        osc_tick,          // Oscillator period pulse
  output wire        sys_tick,          // System clock pulse
  output wire        mc_tick,           // Machine cycle pulse
  output reg  [1:0]  active_sel,        // Selector in force
  output reg         multiplier_lock_ready, // Multiplier stable
  output wire        irq                // Level interrupt
);

  // ----------------------------------------------------------------
  // Engage sequence states
  // ----------------------------------------------------------------
  localparam [3:0] SQ_IDLE  = 4'b0001;  // Waiting for enable clear
  localparam [3:0] SQ_CLR   = 4'b0010;  // Enable cleared
  localparam [3:0] SQ_FACT  = 4'b0100;  // Factor written
  localparam [3:0] SQ_ARMED = 4'b1000;  // Enable set after factor

  localparam integer LOCK_LAST_I = LOCK_OSC_CYCLES - 1;
  localparam [16:0]  LOCK_LAST   = LOCK_LAST_I[16:0];  // Counter is 17 bits wide

  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;

  reg  [1:0]  pend_sel_ff;
  reg         pend_vld_ff;
  reg         multiplier_factor_select_ff;
  reg         multiplier_enable_ff;
  reg         auto_return_enable_ff;
  reg  [3:0]  seq_ff;
  reg  [3:0]  nxt_seq;
  reg  [16:0] lock_cnt_ff;
  reg  [`SCM_IRQ_W-1:0] irq_stat_ff;
  reg  [`SCM_IRQ_W-1:0] irq_en_ff;
  reg  [`SCM_IRQ_W-1:0] irq_set;

  wire        ctl_wr;
  wire [1:0]  new_sel;
  wire        new_fac;
  wire        new_en;
  wire [1:0]  cur_sel;
  wire        sel_change;
  reg         sel_ok;
  wire        sel_take;
  wire        sel_reject;
  wire        in_mult;
  wire        fac_take;
  wire        en_take;
  wire        swback;
  wire        lock_hit;

  // ----------------------------------------------------------------
  // Bus front end and tick generator
  // ----------------------------------------------------------------
  scm_ahb_slave u_bus
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  scm_tick_gen u_tick
  (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .sel      (active_sel),
    .factor   (multiplier_factor_select_ff),
    .osc_tick (osc_tick),
    .sys_tick (sys_tick),
    .mc_tick  (mc_tick)
  );

  // ----------------------------------------------------------------
  // Control write decode
  // ----------------------------------------------------------------
  assign ctl_wr  = wr_en && (wr_addr == `SCM_OFS_CTRL);
  assign new_sel = {wr_data[`SCM_CTL_SEL_HI], wr_data[`SCM_CTL_SEL_LO]};
  assign new_fac = wr_data[`SCM_CTL_FACTOR];
  assign new_en  = wr_data[`SCM_CTL_MULT_EN];

  // Target selector counts a change still waiting for its machine cycle
  assign cur_sel    = pend_vld_ff ? pend_sel_ff : active_sel;
  assign in_mult    = (cur_sel == `SCM_SEL_MULT);
  assign sel_change = ctl_wr && (new_sel != cur_sel);

  // Legality of a selector change
  always @*
  begin
    sel_ok = 1'b0;
    if (new_sel == `SCM_SEL_RSVD)
      sel_ok = 1'b0;                                        // see RQ4
    else if (cur_sel != `SCM_SEL_DIV4 && new_sel != `SCM_SEL_DIV4)
      sel_ok = 1'b0;                                        // see RQ6
    else if (new_sel == `SCM_SEL_MULT)
      sel_ok = (seq_ff == SQ_ARMED) && multiplier_lock_ready
               && !ring_clock_active_flag;                  // see RQ7
    else
      sel_ok = 1'b1;                                        // see RQ11
  end

  // Serial lockout swallows the selector field only
  assign sel_take   = sel_change && sel_ok && !serial_active;   // see RQ14
  assign sel_reject = sel_change && !sel_take;                  // see RQ8

  // Factor and enable stay frozen while the multiplier is the target selector, pending or in force
  assign fac_take = ctl_wr && !in_mult;
  assign en_take  = ctl_wr && !in_mult;

  // Switchback from low power on qualified events
  assign swback = auto_return_enable_ff && (active_sel == `SCM_SEL_PMM)
                  && (irq_ack || ser_start_bit || ser_tx_load);  // see RQ13

  // ----------------------------------------------------------------
  // Engage sequence tracker
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_seq = seq_ff;
    if (en_take)
    begin
      case (seq_ff)
        SQ_IDLE:  nxt_seq = new_en ? SQ_IDLE : SQ_CLR;
        SQ_CLR:   nxt_seq = new_en ? SQ_IDLE : SQ_FACT;
        SQ_FACT:  nxt_seq = new_en ? SQ_ARMED : SQ_FACT;
        SQ_ARMED: nxt_seq = (!new_en || new_fac != multiplier_factor_select_ff)
                            ? SQ_IDLE : SQ_ARMED;
        default:  nxt_seq = SQ_IDLE;
      endcase
      if (cur_sel != `SCM_SEL_DIV4 || ring_clock_active_flag)
        nxt_seq = SQ_IDLE;                                  // see RQ7
    end
    if (sel_take && new_sel == `SCM_SEL_MULT)
      nxt_seq = SQ_IDLE;
  end

  // ----------------------------------------------------------------
  // Control registers and selector pipeline
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      active_sel                  <= `SCM_SEL_RST;          // see RQ4
      pend_sel_ff                 <= `SCM_SEL_RST;
      pend_vld_ff                 <= 1'b0;
      multiplier_factor_select_ff <= 1'b0;
      multiplier_enable_ff        <= 1'b0;
      auto_return_enable_ff       <= 1'b0;
      seq_ff                      <= SQ_IDLE;
    end
    else
    begin
      seq_ff <= nxt_seq;                                    // see RQ8
      if (ctl_wr)
        auto_return_enable_ff <= wr_data[`SCM_CTL_AUTO_RET];
      if (fac_take)
        multiplier_factor_select_ff <= new_fac;             // see RQ3
      if (en_take)
        multiplier_enable_ff <= new_en;
      if (swback)
      begin
        active_sel  <= `SCM_SEL_DIV4;                       // see RQ13
        pend_vld_ff <= 1'b0;
      end
      else if (sel_take)
      begin
        pend_sel_ff <= new_sel;
        pend_vld_ff <= 1'b1;
      end
      else if (pend_vld_ff && mc_tick)
      begin
        active_sel  <= pend_sel_ff;                         // see RQ5
        pend_vld_ff <= 1'b0;                                // see RQ10
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiplier stabilisation counter
  // ----------------------------------------------------------------
  assign lock_hit = osc_tick && (lock_cnt_ff == LOCK_LAST);

  always @(posedge sys_clk)
  begin
    if (sys_rst || !multiplier_enable_ff)
    begin
      lock_cnt_ff           <= 17'h0_0000;                  // see RQ12
      multiplier_lock_ready <= 1'b0;
    end
    else if (!multiplier_lock_ready && osc_tick)
    begin
      lock_cnt_ff <= lock_cnt_ff + 17'h0_0001;
      if (lock_hit)
        multiplier_lock_ready <= 1'b1;                      // see RQ9
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear; a new event beats the clear
  // ----------------------------------------------------------------
  always @*
  begin
    irq_set                 = {`SCM_IRQ_W{1'b0}};
    irq_set[`SCM_IRQ_LOCK]   = lock_hit && multiplier_enable_ff && !multiplier_lock_ready;
    irq_set[`SCM_IRQ_REJECT] = sel_reject;
    irq_set[`SCM_IRQ_SWBACK] = swback;
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= {`SCM_IRQ_W{1'b0}};
      irq_en_ff   <= `SCM_IRQ_EN_RST;
    end
    else
    begin
      if (wr_en && wr_addr == `SCM_OFS_IRQ_CLR)
        irq_stat_ff <= (irq_stat_ff & ~wr_data[`SCM_IRQ_W-1:0]) | irq_set;
      else
        irq_stat_ff <= irq_stat_ff | irq_set;
      if (wr_en && wr_addr == `SCM_OFS_IRQ_EN)
        irq_en_ff <= wr_data[`SCM_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------------------------------
  // Read mux; unmapped and write-only addresses read zero
  // ----------------------------------------------------------------
  always @*
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `SCM_OFS_CTRL:
      begin
        rd_data[`SCM_CTL_SEL_LO]   = cur_sel[0];
        rd_data[`SCM_CTL_SEL_HI]   = cur_sel[1];
        rd_data[`SCM_CTL_FACTOR]   = multiplier_factor_select_ff;
        rd_data[`SCM_CTL_MULT_EN]  = multiplier_enable_ff;
        rd_data[`SCM_CTL_AUTO_RET] = auto_return_enable_ff;
      end
      `SCM_OFS_STAT:
      begin
        rd_data[`SCM_STA_LOCK]    = multiplier_lock_ready;
        rd_data[`SCM_STA_RING]    = ring_clock_active_flag;
        rd_data[`SCM_STA_SER_ACT] = serial_active;
        rd_data[`SCM_STA_ACT_LO]  = active_sel[0];
        rd_data[`SCM_STA_ACT_HI]  = active_sel[1];
        rd_data[`SCM_STA_PEND]    = pend_vld_ff;
        rd_data[`SCM_STA_SEQ_HI:`SCM_STA_SEQ_LO] = seq_ff;
      end
      `SCM_OFS_IRQ_STAT: rd_data[`SCM_IRQ_W-1:0] = irq_stat_ff;
      `SCM_OFS_IRQ_EN:   rd_data[`SCM_IRQ_W-1:0] = irq_en_ff;
      default:           rd_data = 32'h0000_0000;
    endcase
  end

endmodule

//--- test/scm_monitor.sv
// Port-level assertion checker for the clock selector
`timescale 1ns/1ns

module scm_monitor
#(
  parameter LOCK_OSC_CYCLES = 8  // Oscillator cycles to lock
)
(
  input wire       sys_clk,                // Clock
  input wire       sys_rst,                // Reset, high
  input wire       hsel,                   // Slave select
  input wire [1:0] htrans,                 // Transfer type
  input wire       hwrite,                 // Write
  input wire       hready,                 // Bus ready
  input wire       hreadyout,              // Slave ready
  input wire       hresp,                  // Response
  input wire       irq_ack,                // Interrupt taken
  input wire       ser_start_bit,          // Start bit seen
  input wire       ser_tx_load,            // Transmit load
  input wire       osc_tick,               // Oscillator pulse
  input wire       sys_tick,               // System clock pulse
  input wire       mc_tick,                // Machine cycle pulse
  input wire [1:0] active_sel,             // Selector in force
  input wire       multiplier_lock_ready   // Multiplier stable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------
  sequence rd_req_s;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_req_s;
    hsel && hready && htrans[1] && hwrite;
  endsequence

  // Reads take exactly one wait state, writes none
  rd_one_wait_a: assert property (rd_req_s |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  wr_no_wait_a: assert property (wr_req_s |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");

  // --------------------------------------------------------------
  // Selector and clock rates
  // --------------------------------------------------------------
  sel_legal_a: assert property (active_sel != 2'h1)
    else $error("reserved selector active");
  sel_path_a: assert property ($changed(active_sel) |-> $past(active_sel) == 2'h2 || active_sel == 2'h2)
    else $error("selector skipped divide by four");
  sel_on_mc_a: assert property ($changed(active_sel) |-> mc_tick || $past(mc_tick) ||
    ($past(active_sel) == 2'h3 && $past(irq_ack || ser_start_bit || ser_tx_load)))
    else $error("selector changed off machine cycle");
  mult_locked_a: assert property (active_sel == 2'h0 |-> multiplier_lock_ready)
    else $error("multiplier used unlocked");
  osc_period_a: assert property (osc_tick |=> !osc_tick [*3] ##1 osc_tick)
    else $error("oscillator period wrong");
  mc_spacing_a: assert property (mc_tick |=> !mc_tick [*3])
    else $error("machine cycle too short");
  div4_rate_a: assert property (sys_tick && active_sel == 2'h2 && $past(active_sel, 4) == 2'h2
    |=> !sys_tick [*3])
    else $error("divide by four rate too fast");
endmodule

bind scm_top scm_monitor #(.LOCK_OSC_CYCLES(LOCK_OSC_CYCLES)) u_mon
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .irq_ack(irq_ack), .ser_start_bit(ser_start_bit),
  .ser_tx_load(ser_tx_load), .osc_tick(osc_tick), .sys_tick(sys_tick), .mc_tick(mc_tick),
  .active_sel(active_sel), .multiplier_lock_ready(multiplier_lock_ready)
);

//--- test/tb_system_clock_select_multiplier.sv
// Self-checking bench for the clock selector
`timescale 1ns/1ns

module tb_system_clock_select_multiplier;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic        ring = 1'b0, ser = 1'b0, ack = 1'b0, sbit = 1'b0, tld = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  wire  [31:0] hrdata;
  wire  [1:0]  asel;
  wire         hreadyout, hresp, osc_t, sys_t, mc_t, lock, irq;
  int          errors = 0, samples_checked = 0, seed = 32'h0000_d315, f, ev;
  int          m_sel = 2, m_seq = 1, m_fac = 0, m_en = 0, m_auto = 0, m_lock = 0, m_irq = 0, m_ien = 0;

  scm_top #(.LOCK_OSC_CYCLES(8)) DUT
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ring_clock_active_flag(ring), .serial_active(ser), .irq_ack(ack), .ser_start_bit(sbit), .ser_tx_load(tld),
    .osc_tick(osc_t), .sys_tick(sys_t), .mc_tick(mc_t), .active_sel(asel), .multiplier_lock_ready(lock), .irq(irq)
  );

  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // --------------------------------------------------------------
  // Compare, bus and model tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for ready sampled before an edge, then passes that edge
  task automatic rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (hreadyout !== 1'b1 && n < 99)
    begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 99)
      chk("hreadyout", 1, 0);
    d = hrdata;
    @(posedge sys_clk);
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(d);
  endtask

  // Expected register contents from the model
  function automatic logic [31:0] m_rd(int a);
    case (a)
      0: return {m_auto[0], m_en[0], m_fac[0], m_sel[1:0]};
      4: return {m_seq[3:0], 1'b0, m_sel[1:0], ser, ring, m_lock[0]};
      8: return m_irq;
      16: return m_ien;
      default: return 0;
    endcase
  endfunction

  task automatic chk_all;
    logic [31:0] d;
    for (int a = 0; a < 24; a += 4)
      if (a != 12)
      begin
        bus(0, a[7:0], 0, d);
        chk("register", m_rd(a), d);
      end
    chk("active_sel", m_sel[1:0], asel);
    chk("lock", m_lock[0], lock);
    chk("irq", |(m_irq & m_ien), irq);
  endtask

  // Control write, applied to the model by the selector rules
  task automatic wc(input int s, input int fc, input int e);
    logic [31:0] d;
    logic        ok;
    bus(1, 0, {m_auto[0], e[0], fc[0], s[1:0]}, d);
    ok = s != 1 && (s == 2 || m_sel == 2) && !ser && (s != 0 || (m_seq == 8 && m_lock && !ring));
    if (m_sel == 2 && !ring)
      case (m_seq)
        1: m_seq = e ? 1 : 2;
        2: m_seq = e ? 1 : 4;
        4: m_seq = e ? 8 : 4;
        default: m_seq = (e && fc == m_fac) ? 8 : 1;
      endcase
    else
      m_seq = 1;
    if (m_sel != 0)
    begin
      m_fac = fc;
      m_en = e;
      if (!e)
        m_lock = 0;
    end
    if (s != m_sel && !ok)
      m_irq[1] = 1;
    else if (s != m_sel)
    begin
      m_sel = s;
      if (s == 0)
        m_seq = 1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1, a, v, d);
  endtask

  task automatic mc_w(output int n);
    n = 0;
    @(negedge sys_clk);
    while (mc_t !== 1'b1 && n < 9000)
    begin
      n++;
      @(negedge sys_clk);
    end
  endtask

  // Selector lands on the next machine cycle, then the period is measured
  task automatic settle;
    int n;
    mc_w(n);
    @(negedge sys_clk);
    chk("active_sel", m_sel[1:0], asel);
    repeat (2) mc_w(n);
    chk("mc period", m_sel == 0 ? (m_fac ? 4 : 8) : (m_sel == 2 ? 16 : 4096), n + 1);
    chk_all();
  endtask

  // Lock must come after eight oscillator periods
  task automatic lk;
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 99)
    begin
      n++;
      @(negedge sys_clk);
    end
    chk("lock delay", 1, n >= 28 && n <= 44);
    m_lock = 1;
    m_irq[0] = 1;
  endtask

  task automatic arm(input int fc);
    wc(2, fc, 0);
    wc(2, fc, 1);
    lk();
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk_all();
    wr(16, 7);
    m_ien = 7;
    ring <= 1'b1;
    wc(1, 0, 0);
    ser <= 1'b1;
    wc(3, 0, 0);
    ser <= 1'b0;
    wc(0, 0, 0);
    ring <= 1'b0;
    m_auto = 1;
    wc(3, 0, 0);
    settle();
    wc(0, 0, 0);
    chk_all();
    ev = $unsigned($random(seed)) % 3;
    {tld, sbit, ack} <= 3'h1 << ev;
    @(posedge sys_clk);
    {tld, sbit, ack} <= 3'h0;
    @(negedge sys_clk);
    m_sel = 2;
    m_irq[2] = 1;
    chk("switchback", 2, asel);
    settle();
    f = $unsigned($random(seed)) % 2;
    wc(2, 0, 0);
    arm(f);
    ring <= 1'b1;
    wc(0, f, 1);
    ring <= 1'b0;
    wc(2, f, 0);
    wc(2, f, 1);
    lk();
    wc(0, f, 0);
    chk_all();
    arm(f);
    wc(0, f, 1);
    settle();
    wc(3, f, 0);
    chk_all();
    wc(2, f, 0);
    settle();
    wc(2, f, 0);
    chk_all();
    f = 1 - f;
    arm(f);
    wc(0, f, 1);
    settle();
    wc(2, f, 0);
    settle();
    wr(16, 4);
    m_ien = 4;
    chk_all();
    wr(12, 4);
    m_irq[2] = 0;
    chk_all();
    summarize();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule
